// >>> verilog/ifb_cfg.svh
// Constants for the interrupt request flag bank: offsets, masks, reset values
// Operation
// - A flag reads 1 after its source requested, 0 while none occurred.
// - Unimplemented bits of all four flag registers always read zero.
// - Flags 0 high byte: converter 13, serial1 tx/rx 12/11, sport1 10/9, tmr3 8.
// - Flags 0 low: tmr2/cmp2/cap2 7/6/5, tmr1/cmp1/cap1 3/2/1, ext0 0.
// - Flags 1 high: serial2 tx/rx 15/14, ext2/tmr5/tmr4 13/12/11, cmp4/cmp3 10/9.
// - Flags 1 low: ext1 4, pin change 3, comparator 2, twi1 master/slave 1/0.
// - Flags 2: par port 13, cmp5 9, capture5/4/3 at 7/6/5, sport2 event 1, fault 0.
// - Flags 3: calendar 14, ext4 6, ext3 5, twi2 master 2, twi2 slave 1.
// - A source sets its flag; it stays set until software writes it clear.
// - Every flag bit resets to zero.
// - Sources map into the registers in one fixed order, ext0 first.
`ifndef IFB_CFG_SVH
`define IFB_CFG_SVH

`define IFB_ADDR_W 4
`define IFB_DATA_W 16
`define IFB_EXT_PINS 5

`define IFB_ADDR_FLAGS0 4'h0
`define IFB_ADDR_FLAGS1 4'h1
`define IFB_ADDR_FLAGS2 4'h2
`define IFB_ADDR_FLAGS3 4'h3
`define IFB_ADDR_OVR0 4'h4
`define IFB_ADDR_OVR1 4'h5
`define IFB_ADDR_OVR2 4'h6
`define IFB_ADDR_OVR3 4'h7
`define IFB_ADDR_EDGE_POL 4'h8
`define IFB_ADDR_PIN_LEVEL 4'h9

`define IFB_IMPL_MASK0 16'h3FEF
`define IFB_IMPL_MASK1 16'hFE1F
`define IFB_IMPL_MASK2 16'h22E3
`define IFB_IMPL_MASK3 16'h4066

`define IFB_FLAGS_RESET 16'h0000
`define IFB_EDGE_POL_RESET 5'h00

`endif

// >>> verilog/ifb_pkg.sv
// Types shared by the interrupt request flag bank
package ifb_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ifb_bus_req_t;

    // One-cycle request pulses from on-chip peripherals, same clock
    typedef struct packed {
        logic conv_done;
        logic serial1_tx;
        logic serial1_rx;
        logic sport1_event;
        logic sport1_fault;
        logic tmr3;
        logic tmr2;
        logic compare2;
        logic capture2;
        logic tmr1;
        logic compare1;
        logic capture1;
        logic serial2_tx;
        logic serial2_rx;
        logic tmr5;
        logic tmr4;
        logic compare4;
        logic compare3;
        logic pin_change;
        logic comparator;
        logic twi1_master;
        logic twi1_slave;
        logic par_port;
        logic compare5;
        logic capture5;
        logic capture4;
        logic capture3;
        logic sport2_event;
        logic sport2_fault;
        logic calendar;
        logic twi2_master;
        logic twi2_slave;
    } ifb_periph_req_t;

endpackage

// >>> verilog/ifb_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module ifb_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// >>> verilog/ifb_flag_reg.sv
// One 16-bit request flag register with its overrun companion
`timescale 1ns/1ps
`include "ifb_cfg.svh"
module ifb_flag_reg #(
    parameter logic [15:0] IMPL_MASK = 16'h0000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_flags,
    input wire logic wr_ovr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] set_req,
    output logic [15:0] flags,
    output logic [15:0] overrun
);
    logic [15:0] next_flags;
    logic [15:0] next_overrun;

    // Written value replaces the flags, then requests are ORed on top
    assign next_flags = ((wr_flags ? wdata : flags) | set_req) & IMPL_MASK;
    // Request landing on an already pending flag; write 1 clears
    assign next_overrun = ((wr_ovr ? (overrun & ~wdata) : overrun) | (set_req & flags)) & IMPL_MASK;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags <= `IFB_FLAGS_RESET;
            overrun <= `IFB_FLAGS_RESET;
        end else begin
            flags <= next_flags;
            overrun <= next_overrun;
        end
    end
endmodule

// >>> verilog/ifb_top.sv
// Interrupt request flag bank: four flag registers, pin edge capture, register port
`timescale 1ns/1ps
`include "ifb_cfg.svh"
module ifb_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ifb_pkg::ifb_bus_req_t bus_req,
    output logic [15:0] rd_data,
    input wire ifb_pkg::ifb_periph_req_t periph_req,
    input wire logic [4:0] ext_pin,
    output logic conv_done_flag,
    output logic serial1_tx_flag,
    output logic serial1_rx_flag,
    output logic sport1_event_flag,
    output logic sport1_fault_flag,
    output logic tmr3_flag,
    output logic tmr2_flag,
    output logic compare2_flag,
    output logic capture2_flag,
    output logic tmr1_flag,
    output logic compare1_flag,
    output logic capture1_flag,
    output logic ext_irq0_flag,
    output logic serial2_tx_flag,
    output logic serial2_rx_flag,
    output logic ext_irq2_flag,
    output logic tmr5_flag,
    output logic tmr4_flag,
    output logic compare4_flag,
    output logic compare3_flag,
    output logic ext_irq1_flag,
    output logic pin_change_flag,
    output logic comparator_flag,
    output logic twi1_master_flag,
    output logic twi1_slave_flag,
    output logic par_port_flag,
    output logic compare5_flag,
    output logic capture5_flag,
    output logic capture4_flag,
    output logic capture3_flag,
    output logic sport2_event_flag,
    output logic sport2_fault_flag,
    output logic calendar_flag,
    output logic ext_irq4_flag,
    output logic ext_irq3_flag,
    output logic twi2_master_flag,
    output logic twi2_slave_flag,
    output logic any_flag_pending
);
    localparam int NREG = 4;
    localparam logic [63:0] IMPL_MASKS = {
        `IFB_IMPL_MASK3,
        `IFB_IMPL_MASK2,
        `IFB_IMPL_MASK1,
        `IFB_IMPL_MASK0
    };

    // External pin path
    logic [4:0] pin_level;
    logic [4:0] pin_prev;
    logic [4:0] edge_pol;
    logic [4:0] pin_rise;
    logic [4:0] pin_fall;
    logic [4:0] ext_evt;

    // Register port decode
    logic is_flags;
    logic is_ovr;
    logic [1:0] reg_idx;
    logic wr_edge_pol;
    logic [3:0] wr_flags_sel;
    logic [3:0] wr_ovr_sel;

    // Flag storage
    logic [NREG-1:0][15:0] set_vec;
    logic [NREG-1:0][15:0] flags;
    logic [NREG-1:0][15:0] overrun;

    logic [15:0] read_mux;
    logic [15:0] next_rd_data;
    logic next_any_pending;

    // Pins come from outside the clock domain
    ifb_sync #(
        .WIDTH(`IFB_EXT_PINS)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(ext_pin),
        .sync_out(pin_level)
    );

    // Edge select per pin: 0 rising, 1 falling
    assign pin_rise = pin_level & ~pin_prev;
    assign pin_fall = ~pin_level & pin_prev;
    assign ext_evt = (pin_fall & edge_pol) | (pin_rise & ~edge_pol);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_prev <= 5'h00;
        end else begin
            pin_prev <= pin_level;
        end
    end

    // Register port decode
    assign is_flags = (bus_req.addr[3:2] == 2'h0);
    assign is_ovr = (bus_req.addr[3:2] == 2'h1);
    assign reg_idx = bus_req.addr[1:0];
    assign wr_edge_pol = bus_req.wr && (bus_req.addr == `IFB_ADDR_EDGE_POL);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            edge_pol <= `IFB_EDGE_POL_RESET;
        end else if (wr_edge_pol) begin
            edge_pol <= bus_req.wdata[4:0];
        end
    end

    // Source order: external interrupt zero holds the first position
    assign set_vec[0] = {
        2'h0,
        periph_req.conv_done,
        periph_req.serial1_tx,
        periph_req.serial1_rx,
        periph_req.sport1_event,
        periph_req.sport1_fault,
        periph_req.tmr3,
        periph_req.tmr2,
        periph_req.compare2,
        periph_req.capture2,
        1'h0,
        periph_req.tmr1,
        periph_req.compare1,
        periph_req.capture1,
        ext_evt[0]
    };
    assign set_vec[1] = {
        periph_req.serial2_tx,
        periph_req.serial2_rx,
        ext_evt[2],
        periph_req.tmr5,
        periph_req.tmr4,
        periph_req.compare4,
        periph_req.compare3,
        4'h0,
        ext_evt[1],
        periph_req.pin_change,
        periph_req.comparator,
        periph_req.twi1_master,
        periph_req.twi1_slave
    };
    assign set_vec[2] = {
        2'h0,
        periph_req.par_port,
        3'h0,
        periph_req.compare5,
        1'h0,
        periph_req.capture5,
        periph_req.capture4,
        periph_req.capture3,
        3'h0,
        periph_req.sport2_event,
        periph_req.sport2_fault
    };
    assign set_vec[3] = {
        1'h0,
        periph_req.calendar,
        7'h00,
        ext_evt[4],
        ext_evt[3],
        2'h0,
        periph_req.twi2_master,
        periph_req.twi2_slave,
        1'h0
    };

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            assign wr_flags_sel[gi] = bus_req.wr && is_flags && (reg_idx == 2'(gi));
            assign wr_ovr_sel[gi] = bus_req.wr && is_ovr && (reg_idx == 2'(gi));

            // Mask also forces unimplemented positions to zero
            ifb_flag_reg #(
                .IMPL_MASK(IMPL_MASKS[16*gi +: 16])
            ) u_flag_reg (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .wr_flags(wr_flags_sel[gi]),
                .wr_ovr(wr_ovr_sel[gi]),
                .wdata(bus_req.wdata),
                .set_req(set_vec[gi]),
                .flags(flags[gi]),
                .overrun(overrun[gi])
            );
        end
    endgenerate

    // Read path; unmapped addresses read zero
    assign read_mux = is_flags ? flags[reg_idx] :
                      is_ovr ? overrun[reg_idx] :
                      (bus_req.addr == `IFB_ADDR_EDGE_POL) ? {11'h000, edge_pol} :
                      (bus_req.addr == `IFB_ADDR_PIN_LEVEL) ? {11'h000, pin_level} :
                      16'h0000;
    // Data only in the cycle after the strobe
    assign next_rd_data = bus_req.rd ? read_mux : 16'h0000;
    assign next_any_pending = |{flags[3], flags[2], flags[1], flags[0]};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
            any_flag_pending <= 1'h0;
        end else begin
            rd_data <= next_rd_data;
            any_flag_pending <= next_any_pending;
        end
    end

    // Per-source flag outputs, straight from the flag flops
    assign conv_done_flag = flags[0][13];
    assign serial1_tx_flag = flags[0][12];
    assign serial1_rx_flag = flags[0][11];
    assign sport1_event_flag = flags[0][10];
    assign sport1_fault_flag = flags[0][9];
    assign tmr3_flag = flags[0][8];
    assign tmr2_flag = flags[0][7];
    assign compare2_flag = flags[0][6];
    assign capture2_flag = flags[0][5];
    assign tmr1_flag = flags[0][3];
    assign compare1_flag = flags[0][2];
    assign capture1_flag = flags[0][1];
    assign ext_irq0_flag = flags[0][0];
    assign serial2_tx_flag = flags[1][15];
    assign serial2_rx_flag = flags[1][14];
    assign ext_irq2_flag = flags[1][13];
    assign tmr5_flag = flags[1][12];
    assign tmr4_flag = flags[1][11];
    assign compare4_flag = flags[1][10];
    assign compare3_flag = flags[1][9];
    assign ext_irq1_flag = flags[1][4];
    assign pin_change_flag = flags[1][3];
    assign comparator_flag = flags[1][2];
    assign twi1_master_flag = flags[1][1];
    assign twi1_slave_flag = flags[1][0];
    assign par_port_flag = flags[2][13];
    assign compare5_flag = flags[2][9];
    assign capture5_flag = flags[2][7];
    assign capture4_flag = flags[2][6];
    assign capture3_flag = flags[2][5];
    assign sport2_event_flag = flags[2][1];
    assign sport2_fault_flag = flags[2][0];
    assign calendar_flag = flags[3][14];
    assign ext_irq4_flag = flags[3][6];
    assign ext_irq3_flag = flags[3][5];
    assign twi2_master_flag = flags[3][2];
    assign twi2_slave_flag = flags[3][1];
endmodule

// >>> verification/ifb_top_assertions.sv
// Concurrent checks on the request flag bank ports
`timescale 1ns/1ps
module ifb_top_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ifb_pkg::ifb_bus_req_t bus_req,
    input wire logic [15:0] rd_data,
    input wire ifb_pkg::ifb_periph_req_t periph_req,
    input wire logic tmr1_flag,
    input wire logic conv_done_flag,
    input wire logic tmr2_flag,
    input wire logic par_port_flag,
    input wire logic calendar_flag,
    input wire logic ext_irq1_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 16'h0000)
        else $error("read data not zero outside read answer");
    a_tmr1_set: assert property (periph_req.tmr1 |=> tmr1_flag)
        else $error("timer one request lost");
    a_conv_set: assert property (periph_req.conv_done |=> conv_done_flag)
        else $error("converter request lost");
    a_flag_holds: assert property (tmr1_flag && !(bus_req.wr && bus_req.addr == 4'h0)
        |=> tmr1_flag)
        else $error("flag dropped without a clearing write");
    a_no_spurious: assert property (!tmr2_flag && !periph_req.tmr2
        && !(bus_req.wr && bus_req.addr == 4'h0) |=> !tmr2_flag)
        else $error("flag set without a request");
    a_wr_sets: assert property (bus_req.wr && bus_req.addr == 4'h2 && bus_req.wdata[13]
        |=> par_port_flag)
        else $error("software set of parallel port flag failed");
    a_wr_clears: assert property (bus_req.wr && bus_req.addr == 4'h3 && !bus_req.wdata[14]
        && !periph_req.calendar |=> !calendar_flag)
        else $error("software clear of calendar flag failed");
    a_unimpl_zero: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 4'h0
        |-> rd_data[15:14] == 2'b00 && !rd_data[4])
        else $error("unimplemented bits of flags 0 read nonzero");
    a_read_map: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 4'h1
        |-> rd_data[4] == $past(ext_irq1_flag))
        else $error("ext one flag not at bit 4 of flags 1");
endmodule

// >>> verification/ifb_src_model.sv
// Peripheral and pin request source for the flag bank bench
`timescale 1ns/1ps
module ifb_src_model (
    input wire logic clk_sys,
    output ifb_pkg::ifb_periph_req_t periph_req,
    output logic [4:0] ext_pin
);
    logic [31:0] req_v = 32'h00000000;
    assign periph_req = req_v;
    initial ext_pin = 5'h00;
    // One-cycle request pulse from a peripheral
    task automatic pulse(input int idx);
        @(posedge clk_sys);
        req_v[idx] <= 1'b1;
        @(posedge clk_sys);
        req_v[idx] <= 1'b0;
    endtask
    // Levels held well past the sync depth so the edge is never missed
    task automatic pin_edge(input int idx);
        @(posedge clk_sys);
        ext_pin[idx] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ext_pin[idx] <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// >>> verification/ifb_top_tb.sv
// Self-checking bench for the request flag bank
`timescale 1ns/1ps
module ifb_top_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    ifb_pkg::ifb_bus_req_t bus_req = '0;
    ifb_pkg::ifb_periph_req_t periph_req;
    logic [4:0] ext_pin;
    logic [15:0] rd_data;
    logic [15:0] got;
    // Flag outputs in source order: periph bits 31..0, then pins 0..4
    wire [36:0] flag_out;
    wire any_pend;
    int n_mismatch = 0;
    int checks = 0;
    // Register in upper nibble, bit in lower; periph bits 31..0, then pins 0..4
    logic [7:0] src_map [37] = '{8'h0D, 8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08, 8'h07, 8'h06,
        8'h05, 8'h03, 8'h02, 8'h01, 8'h1F, 8'h1E, 8'h1C, 8'h1B, 8'h1A, 8'h19, 8'h13, 8'h12,
        8'h11, 8'h10, 8'h2D, 8'h29, 8'h27, 8'h26, 8'h25, 8'h21, 8'h20, 8'h3E, 8'h32, 8'h31,
        8'h00, 8'h14, 8'h1D, 8'h35, 8'h36};
    // Address, write data, expected read back
    logic [35:0] rows [9] = '{{4'h0, 16'hFFFF, 16'h3FEF}, {4'h1, 16'hFFFF, 16'hFE1F},
        {4'h2, 16'hFFFF, 16'h22E3}, {4'h3, 16'hFFFF, 16'h4066}, {4'h0, 16'h0000, 16'h0000},
        {4'h1, 16'h0000, 16'h0000}, {4'h2, 16'h0000, 16'h0000}, {4'h3, 16'h0000, 16'h0000},
        {4'hA, 16'hFFFF, 16'h0000}};

    ifb_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
        .periph_req(periph_req), .ext_pin(ext_pin), .any_flag_pending(any_pend),
        .conv_done_flag(flag_out[0]), .serial1_tx_flag(flag_out[1]),
        .serial1_rx_flag(flag_out[2]), .sport1_event_flag(flag_out[3]),
        .sport1_fault_flag(flag_out[4]), .tmr3_flag(flag_out[5]), .tmr2_flag(flag_out[6]),
        .compare2_flag(flag_out[7]), .capture2_flag(flag_out[8]), .tmr1_flag(flag_out[9]),
        .compare1_flag(flag_out[10]), .capture1_flag(flag_out[11]),
        .serial2_tx_flag(flag_out[12]), .serial2_rx_flag(flag_out[13]),
        .tmr5_flag(flag_out[14]), .tmr4_flag(flag_out[15]), .compare4_flag(flag_out[16]),
        .compare3_flag(flag_out[17]), .pin_change_flag(flag_out[18]),
        .comparator_flag(flag_out[19]), .twi1_master_flag(flag_out[20]),
        .twi1_slave_flag(flag_out[21]), .par_port_flag(flag_out[22]),
        .compare5_flag(flag_out[23]), .capture5_flag(flag_out[24]),
        .capture4_flag(flag_out[25]), .capture3_flag(flag_out[26]),
        .sport2_event_flag(flag_out[27]), .sport2_fault_flag(flag_out[28]),
        .calendar_flag(flag_out[29]), .twi2_master_flag(flag_out[30]),
        .twi2_slave_flag(flag_out[31]), .ext_irq0_flag(flag_out[32]),
        .ext_irq1_flag(flag_out[33]), .ext_irq2_flag(flag_out[34]),
        .ext_irq3_flag(flag_out[35]), .ext_irq4_flag(flag_out[36]));
    ifb_src_model src_u (.clk_sys(clk_sys), .periph_req(periph_req), .ext_pin(ext_pin));

    initial forever #4 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #40000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            rd_reg(r[3:0], got);
            check("reset value", 16'h0000, got);
            check("pending at reset", 16'h0000, {15'h0000, any_pend});
        end
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            wr_reg(rows[i][35:32], rows[i][31:16]);
            rd_reg(rows[i][35:32], got);
            check("register row", rows[i][15:0], got);
        end
        $display("test register rows done");
        for (int i = 0; i < 37; i++) begin
            for (int r = 0; r < 4; r++) wr_reg(r[3:0], 16'h0000);
            if (i < 32) src_u.pulse(31 - i);
            else src_u.pin_edge(i - 32);
            repeat (8) @(posedge clk_sys);
            rd_reg({2'b00, src_map[i][5:4]}, got);
            check("source flag", 16'h0001 << src_map[i][3:0], got);
            check("flag output", 16'h0001, {15'h0000, flag_out[i]});
            check("others", 16'h0000, {15'h0000, |(flag_out & ~(37'h1 << i))});
            check("pending", 16'h0001, {15'h0000, any_pend});
        end
        $display("test source mapping done");
        wr_reg(4'h0, 16'h0008);
        fork
            wr_reg(4'h0, 16'h0000);
            src_u.pulse(22);
        join
        rd_reg(4'h0, got);
        check("set beats clear", 16'h0008, got);
        // Request hit a flag that was already pending
        rd_reg(4'h4, got);
        check("overrun", 16'h0008, got);
        wr_reg(4'h4, 16'h0008);
        rd_reg(4'h4, got);
        check("overrun cleared", 16'h0000, got);
        repeat (20) @(posedge clk_sys);
        rd_reg(4'h0, got);
        check("flag held", 16'h0008, got);
        wr_reg(4'h0, 16'h0000);
        rd_reg(4'h0, got);
        check("flag cleared", 16'h0000, got);
        $display("test set and clear done");
        wr_reg(4'h8, 16'h0001);
        rd_reg(4'h8, got);
        check("edge polarity", 16'h0001, got);
        // Falling mode: the rise must leave the flag clear
        fork
            src_u.pin_edge(0);
            begin
                repeat (5) @(posedge clk_sys);
                rd_reg(4'h9, got);
                check("pin level", 16'h0001, got);
                rd_reg(4'h0, got);
                check("no set on rise", 16'h0000, got);
            end
        join
        rd_reg(4'h0, got);
        check("set on fall", 16'h0001, got);
        $display("test falling edge done");
        wr_reg(4'h1, 16'hFFFF);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_reg(4'h1, got);
        check("second reset", 16'h0000, got);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule

bind ifb_top ifb_top_checker chk_u (.clk_sys, .rst_n, .bus_req, .rd_data, .periph_req,
    .tmr1_flag, .conv_done_flag, .tmr2_flag, .par_port_flag, .calendar_flag, .ext_irq1_flag);
